/* wdsr_pkg.sv */
// Constants, types and state layout for the supervision timer and system reset block.
// Assumes a single 20 MHz clock and monitor inputs produced on that clock.
//
// Operation
// R1 - Host toggles kick pin; device restarts count
// R2 - Missed kick declares timeout, pulses timeout output
// R3 - Bus restart command also restarts the count
// R4 - Period programmable from 0.001 s to 258.048 s
// R5 - After timeout, kick or command restarts supervision
// R6 - Start immediately or after 100 ms doubling wait
// R7 - Timeout routable to pin, general output, reset
// R8 - Release reset after rails good, inputs asserted, delay
// R9 - Release delay 0 ms or 1 ms doubling
// R10 - Level mode: loss of rail or input asserts reset
// R11 - Pulse mode: one pulse, 0.001 s to 32.256 s
// R12 - Merged timeout toggles reset, released after delay; in pulse mode the code releases it after the pulse width (pulse_ms) instead
// R13 - Reset output comes up asserted
// R14 - Reconfiguration briefly asserts reset during re-evaluation
// R15 - Either kick edge counts, pin synchronised first
package wdsr_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TICK_W = 15;
  localparam int CNT_W = 22;
  localparam int WD_PERIOD_MIN_MS = 1;
  localparam int WD_PERIOD_MAX_MS = 258048;
  localparam int WD_PERIOD_W = 18;
  localparam int START_BASE_MS = 100;
  localparam int START_SEL_W = 4;
  localparam int DELAY_SEL_W = 5;
  localparam int DELAY_SEL_MAX = 16;
  localparam int PULSE_MIN_MS = 1;
  localparam int PULSE_MAX_MS = 32256;
  localparam int PULSE_W = 15;
  localparam logic [1:0] TIMEOUT_PULSE_MS = 2'h1;
  localparam int RAIL_N = 24;
  localparam int GPI_N = 32;
  localparam logic [CNT_W-1:0] CNT_ZERO = 22'h0;
  localparam logic [TICK_W-1:0] TICK_ZERO = 15'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {WD_OFF, WD_START, WD_RUN, WD_EXPIRED} wdsr_wd_e;
  typedef enum logic [2:0] {RS_HOLD, RS_DELAY, RS_PULSE, RS_RUN, RS_REARM} wdsr_rs_e;

  typedef struct packed {
    logic wd_enable;
    logic [WD_PERIOD_W-1:0] wd_period_ms;
    logic [START_SEL_W-1:0] start_sel;
    logic to_pin;
    logic to_gpo;
    logic to_reset;
    logic [DELAY_SEL_W-1:0] delay_sel;
    logic pulse_mode;
    logic [PULSE_W-1:0] pulse_ms;
    logic [RAIL_N-1:0] rail_sel;
    logic [GPI_N-1:0] gpi_sel;
  } wdsr_cfg_s;

  typedef struct packed {
    logic [TICK_W-1:0] tick_cnt;
    logic kick_prev;
    wdsr_wd_e wd;
    logic [CNT_W-1:0] wd_cnt;
    logic timeout_pulse;
    logic [1:0] to_cnt;
    wdsr_rs_e rs;
    logic [CNT_W-1:0] rs_cnt;
    logic out_to_pin;
    logic out_to_gpo;
    logic out_rst_n;
  } wdsr_st_s;

  localparam wdsr_st_s ST_RESET = '{
    tick_cnt: TICK_ZERO, kick_prev: 1'b0, wd: WD_OFF, wd_cnt: CNT_ZERO,
    timeout_pulse: 1'b0, to_cnt: 2'h0, rs: RS_HOLD, rs_cnt: CNT_ZERO,
    out_to_pin: 1'b0, out_to_gpo: 1'b0, out_rst_n: 1'b0};

endpackage

/* wdsr_sync.sv */
// Two-stage synchroniser for pin inputs.
// Assumes inputs are asynchronous to clk_sys.
`timescale 1ns/1ns
module wdsr_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // wdsr_sync

/* wdsr_watchdog_reset.sv */
// Supervision timer and system reset generator.
// Assumes rail monitor and bus command inputs are on clk_sys; kick and GPIs are pins.
`timescale 1ns/1ns
module wdsr_watchdog_reset #(
  parameter int TICK_CYCLES = wdsr_pkg::TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic kick_input,
  input wire logic restart_cmd,
  input wire logic cfg_write,
  input wire wdsr_pkg::wdsr_cfg_s cfg,
  input wire logic [wdsr_pkg::RAIL_N-1:0] rail_pg_on,
  input wire logic [wdsr_pkg::RAIL_N-1:0] rail_below_pg_off,
  input wire logic [wdsr_pkg::GPI_N-1:0] gpi_pin,
  output logic timeout_output,
  output logic timeout_gpo,
  output logic sys_reset_n,
  output logic wd_expired
);

  // ----------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------
  function automatic logic [wdsr_pkg::CNT_W-1:0] start_ms(
    input logic [wdsr_pkg::START_SEL_W-1:0] sel);
    logic [wdsr_pkg::CNT_W-1:0] base;
    base = wdsr_pkg::CNT_W'(wdsr_pkg::START_BASE_MS);
    start_ms = (sel == 4'h0) ? wdsr_pkg::CNT_ZERO : base << (sel - 4'h1);
  endfunction

  function automatic logic [wdsr_pkg::CNT_W-1:0] delay_ms(
    input logic [wdsr_pkg::DELAY_SEL_W-1:0] sel);
    logic [wdsr_pkg::DELAY_SEL_W-1:0] s;
    // Codes past the top step saturate at the longest delay
    s = (sel > 5'(wdsr_pkg::DELAY_SEL_MAX)) ? 5'(wdsr_pkg::DELAY_SEL_MAX) : sel;
    delay_ms = (s == 5'h0) ? wdsr_pkg::CNT_ZERO : 22'h1 << (s - 5'h1);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [wdsr_pkg::GPI_N:0] pins_s;
  logic kick_s;
  logic [wdsr_pkg::GPI_N-1:0] gpi_s;

  wdsr_sync #(.W(wdsr_pkg::GPI_N + 1)) u_sync ( // [R15]
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d({kick_input, gpi_pin}),
    .q(pins_s)
  );

  assign kick_s = pins_s[wdsr_pkg::GPI_N];
  assign gpi_s = pins_s[wdsr_pkg::GPI_N-1:0];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  wdsr_pkg::wdsr_st_s st;
  wdsr_pkg::wdsr_st_s next_st;
  logic tick;
  logic kick;
  logic restart;
  logic timeout;
  logic conds_ok;
  logic loss;
  logic merge_to;
  logic [wdsr_pkg::CNT_W-1:0] period;
  logic [wdsr_pkg::CNT_W-1:0] pulse_len;

  always_comb begin
    next_st = st;
    tick = (st.tick_cnt == wdsr_pkg::TICK_W'(TICK_CYCLES - 1));
    next_st.tick_cnt = tick ? wdsr_pkg::TICK_ZERO : st.tick_cnt + 15'h1;
    kick = kick_s ^ st.kick_prev; // [R15]
    next_st.kick_prev = kick_s;
    restart = kick | restart_cmd; // [R1] [R3]
    period = wdsr_pkg::CNT_W'(cfg.wd_period_ms); // [R4]
    pulse_len = wdsr_pkg::CNT_W'(cfg.pulse_ms);
    timeout = 1'b0;

    // Supervision timer
    case (st.wd)
      wdsr_pkg::WD_OFF: begin
        if (cfg.wd_enable) begin
          if (cfg.start_sel == 4'h0) begin // [R6]
            next_st.wd = wdsr_pkg::WD_RUN;
            next_st.wd_cnt = period;
          end else begin
            next_st.wd = wdsr_pkg::WD_START;
            next_st.wd_cnt = start_ms(cfg.start_sel); // [R6]
          end
        end
      end
      wdsr_pkg::WD_START: begin
        // Kicks are not supervised during the start wait
        if (tick) begin
          if (st.wd_cnt <= 22'h1) begin
            next_st.wd = wdsr_pkg::WD_RUN;
            next_st.wd_cnt = period;
          end else begin
            next_st.wd_cnt = st.wd_cnt - 22'h1;
          end
        end
      end
      wdsr_pkg::WD_RUN: begin
        if (restart) begin
          next_st.wd_cnt = period; // [R1] [R3]
        end else if (tick) begin
          if (st.wd_cnt <= 22'h1) begin
            timeout = 1'b1; // [R2]
            next_st.wd = wdsr_pkg::WD_EXPIRED;
          end else begin
            next_st.wd_cnt = st.wd_cnt - 22'h1; // [R4]
          end
        end
      end
      default: begin
        if (restart) begin // [R5]
          next_st.wd = wdsr_pkg::WD_RUN;
          next_st.wd_cnt = period;
        end
      end
    endcase
    if (!cfg.wd_enable) begin
      next_st.wd = wdsr_pkg::WD_OFF;
      timeout = 1'b0;
    end

    // Timeout pulse, at least one millisecond wide
    if (timeout) begin
      next_st.timeout_pulse = 1'b1; // [R2]
      next_st.to_cnt = wdsr_pkg::TIMEOUT_PULSE_MS;
    end else if (st.timeout_pulse && tick) begin
      if (st.to_cnt <= 2'h1) begin
        next_st.timeout_pulse = 1'b0;
      end else begin
        next_st.to_cnt = st.to_cnt - 2'h1;
      end
    end
    next_st.out_to_pin = next_st.timeout_pulse & cfg.to_pin; // [R7]
    next_st.out_to_gpo = next_st.timeout_pulse & cfg.to_gpo; // [R7]

    // System reset
    conds_ok = (&(rail_pg_on | ~cfg.rail_sel)) & (&(gpi_s | ~cfg.gpi_sel)); // [R8]
    loss = (|(rail_below_pg_off & cfg.rail_sel)) | (|(~gpi_s & cfg.gpi_sel)); // [R10]
    merge_to = timeout & cfg.to_reset; // [R7]
    if (cfg_write) begin
      // Conditions are re-examined from scratch after a reconfiguration
      next_st.rs = wdsr_pkg::RS_HOLD; // [R14]
    end else if (merge_to) begin
      if (cfg.pulse_mode) begin
        next_st.rs = wdsr_pkg::RS_PULSE; // [R12]
        next_st.rs_cnt = pulse_len;
      end else begin
        next_st.rs = wdsr_pkg::RS_DELAY; // [R12]
        next_st.rs_cnt = delay_ms(cfg.delay_sel);
      end
    end else begin
      case (st.rs)
        wdsr_pkg::RS_HOLD: begin
          if (conds_ok) begin
            if (cfg.pulse_mode) begin
              next_st.rs = wdsr_pkg::RS_PULSE; // [R11]
              next_st.rs_cnt = pulse_len;
            end else begin
              next_st.rs = wdsr_pkg::RS_DELAY; // [R8]
              next_st.rs_cnt = delay_ms(cfg.delay_sel); // [R9]
            end
          end
        end
        wdsr_pkg::RS_DELAY: begin
          // Losing an input restarts tracking: release waits for it again
          if (loss) begin
            next_st.rs = wdsr_pkg::RS_HOLD; // [R10]
          end else if (st.rs_cnt == wdsr_pkg::CNT_ZERO) begin
            next_st.rs = wdsr_pkg::RS_RUN; // [R8]
          end else if (tick) begin
            next_st.rs_cnt = st.rs_cnt - 22'h1; // [R9]
          end
        end
        wdsr_pkg::RS_PULSE: begin
          if (tick) begin
            if (st.rs_cnt <= 22'h1) begin
              next_st.rs = wdsr_pkg::RS_RUN; // [R11]
            end else begin
              next_st.rs_cnt = st.rs_cnt - 22'h1;
            end
          end
        end
        wdsr_pkg::RS_RUN: begin
          if (loss) begin
            next_st.rs = cfg.pulse_mode ? wdsr_pkg::RS_REARM : wdsr_pkg::RS_HOLD; // [R10]
          end
        end
        default: begin
          if (conds_ok) begin
            next_st.rs = wdsr_pkg::RS_PULSE; // [R11]
            next_st.rs_cnt = pulse_len;
          end
        end
      endcase
    end
    next_st.out_rst_n = (next_st.rs == wdsr_pkg::RS_RUN) ||
                        (next_st.rs == wdsr_pkg::RS_REARM);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= wdsr_pkg::ST_RESET; // [R13]
    end else begin
      st <= next_st;
    end
  end

  assign timeout_output = st.out_to_pin;
  assign timeout_gpo = st.out_to_gpo;
  assign sys_reset_n = st.out_rst_n;
  assign wd_expired = (st.wd == wdsr_pkg::WD_EXPIRED);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  kick_reload_a: assert property ( // [R1]
    (st.wd == wdsr_pkg::WD_RUN && kick && cfg.wd_enable) |=>
      (st.wd == wdsr_pkg::WD_RUN && st.wd_cnt == 22'($past(cfg.wd_period_ms))))
    else $error("kick did not reload the supervision count");

  timeout_fire_a: assert property ( // [R2]
    (st.wd == wdsr_pkg::WD_RUN && cfg.wd_enable && tick && !restart &&
     st.wd_cnt <= 22'h1) |=> (st.timeout_pulse && st.wd == wdsr_pkg::WD_EXPIRED))
    else $error("missed kick did not raise a timeout");

  cmd_restart_a: assert property ( // [R5]
    (st.wd == wdsr_pkg::WD_EXPIRED && restart_cmd && cfg.wd_enable) |=>
      (st.wd == wdsr_pkg::WD_RUN))
    else $error("restart command did not restart supervision");

  start_wait_a: assert property ( // [R6]
    (st.wd == wdsr_pkg::WD_OFF && cfg.wd_enable && cfg.start_sel != 4'h0) |=>
      (st.wd == wdsr_pkg::WD_START && st.wd_cnt == start_ms($past(cfg.start_sel))))
    else $error("start wait not loaded");

  pin_route_a: assert property ( // [R7]
    timeout_output |-> (st.timeout_pulse && $past(cfg.to_pin)))
    else $error("timeout pin driven without routing");

  release_delay_a: assert property ( // [R8]
    $rose(sys_reset_n) |-> ($past(st.rs) == wdsr_pkg::RS_DELAY ||
                            $past(st.rs) == wdsr_pkg::RS_PULSE))
    else $error("reset released outside delay or pulse");

  delay_load_a: assert property ( // [R9]
    (st.rs == wdsr_pkg::RS_HOLD && conds_ok && !cfg.pulse_mode && !cfg_write &&
     !merge_to) |=> (st.rs == wdsr_pkg::RS_DELAY &&
                     st.rs_cnt == delay_ms($past(cfg.delay_sel))))
    else $error("release delay not loaded");

  level_loss_a: assert property ( // [R10]
    (st.rs == wdsr_pkg::RS_RUN && loss && !cfg.pulse_mode) |=> !sys_reset_n)
    else $error("loss did not assert reset");

  pulse_width_a: assert property ( // [R11]
    (st.rs == wdsr_pkg::RS_REARM && conds_ok && !cfg_write && !merge_to) |=>
      (!sys_reset_n && st.rs_cnt == 22'($past(cfg.pulse_ms))))
    else $error("reset pulse not started with its width");

  merge_toggle_a: assert property ( // [R12]
    (merge_to && !cfg_write) |=> !sys_reset_n)
    else $error("merged timeout did not toggle reset");

  cfg_hold_a: assert property ( // [R14]
    cfg_write |=> (!sys_reset_n && st.rs == wdsr_pkg::RS_HOLD))
    else $error("reconfiguration did not assert reset");

endmodule // wdsr_watchdog_reset

/* wdsr_host.sv */
// Host model that restarts the supervision timer through the kick pin.
// Assumes the bench turns kicking on and off; the pin holds its level between kicks.
`timescale 1ns/1ns
module wdsr_host #(
  parameter int GAP = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic kick_on,
  output logic kick_input
);
  // ----------------------------------------------------------------
  // Kick generator
  // ----------------------------------------------------------------
  int cnt = 0;
  initial kick_input = 1'b0;
  // Pin is driven, never released, so it keeps its last level between kicks
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
    end else if (kick_on && cnt >= GAP - 1) begin
      cnt <= 0;
      kick_input <= #5 ~kick_input;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // wdsr_host

/* watchdog_and_system_reset_bench.sv */
// Testbench for the supervision timer and system reset block.
// Assumes a tick of four clocks, so every ms count is four clocks long.
`timescale 1ns/1ns
module watchdog_and_system_reset_bench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int TC = 4;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic restart_cmd = 1'b0;
  logic cfg_write = 1'b0;
  logic kick_on = 1'b0;
  wdsr_pkg::wdsr_cfg_s cfg = '0;
  logic [wdsr_pkg::RAIL_N-1:0] rail_pg_on = 24'h0;
  logic [wdsr_pkg::RAIL_N-1:0] rail_below_pg_off = 24'hffffff;
  logic [wdsr_pkg::GPI_N-1:0] gpi_pin = 32'h0;
  logic kick_input;
  logic timeout_output;
  logic timeout_gpo;
  logic sys_reset_n;
  logic wd_expired;
  int error_cnt = 0;
  int checked = 0;
  int to_cnt = 0;
  int n;

  always #25 clk_sys = ~clk_sys;
  always @(posedge timeout_output) to_cnt++;

  wdsr_host i_wdsr_host (.clk_sys(clk_sys), .rst_n(rst_n), .kick_on(kick_on),
    .kick_input(kick_input));
  wdsr_watchdog_reset #(.TICK_CYCLES(TC)) i_wdsr_watchdog_reset (.clk_sys(clk_sys),
    .rst_n(rst_n), .kick_input(kick_input), .restart_cmd(restart_cmd),
    .cfg_write(cfg_write), .cfg(cfg), .rail_pg_on(rail_pg_on),
    .rail_below_pg_off(rail_below_pg_off), .gpi_pin(gpi_pin),
    .timeout_output(timeout_output), .timeout_gpo(timeout_gpo),
    .sys_reset_n(sys_reset_n), .wd_expired(wd_expired));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic step(input int c);
    repeat (c) @(posedge clk_sys);
    #5;
  endtask

  task automatic check(input string name, input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", name, exp, seen);
    end
  endtask

  // Bounded wait; sel 1 watches the timeout pin, sel 0 the reset output
  task automatic wait_sig(input bit sel, input logic lvl, input int lim, output int c);
    c = 0;
    while (((sel ? timeout_output : sys_reset_n) !== lvl) && c < lim) begin
      step(1);
      c++;
    end
  endtask

  // Reconfiguration must pull reset low even when release conditions hold
  task automatic reconf();
    cfg_write = 1'b1;
    step(1);
    cfg_write = 1'b0;
    check("reset on reconfig", sys_reset_n, 1'b0);
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    cfg.rail_sel = 24'h1;
    cfg.gpi_sel = 32'h1;
    cfg.delay_sel = 5'h3;
    cfg.to_pin = 1'b1;
    cfg.to_gpo = 1'b1;
    cfg.to_reset = 1'b1;
    cfg.wd_period_ms = 18'h5;
    cfg.pulse_ms = 15'h3;
    step(3);
    rst_n = 1'b1;
    check("reset at start", sys_reset_n, 1'b0);
    check("timeout idle", timeout_output, 1'b0);
    rail_pg_on = 24'h1;
    rail_below_pg_off = 24'h0;
    step(20);
    check("held without input", sys_reset_n, 1'b0);
    gpi_pin = 32'h1;
    wait_sig(0, 1'b1, 60, n);
    check("release delay 4 ms", n >= 16 && n <= 28, 1'b1);
    rail_below_pg_off = 24'h1;
    step(2);
    check("rail loss", sys_reset_n, 1'b0);
    rail_below_pg_off = 24'h0;
    wait_sig(0, 1'b1, 60, n);
    gpi_pin = 32'h0;
    step(4);
    check("input loss", sys_reset_n, 1'b0);
    gpi_pin = 32'h1;
    wait_sig(0, 1'b1, 60, n);
    check("release again", n < 60, 1'b1);
    cfg.wd_enable = 1'b1;
    reconf();
    kick_on = 1'b1;
    step(200);
    check("kicks hold off", to_cnt == 0, 1'b1);
    kick_on = 1'b0;
    repeat (25) begin
      restart_cmd = 1'b1;
      step(1);
      restart_cmd = 1'b0;
      step(7);
    end
    check("commands hold off", to_cnt == 0, 1'b1);
    wait_sig(1, 1'b1, 40, n);
    check("timeout fires", n < 40, 1'b1);
    check("timeout to gpo", timeout_gpo, 1'b1);
    check("expired flag", wd_expired, 1'b1);
    wait_sig(0, 1'b0, 3, n);
    check("merged reset", n < 3, 1'b1);
    wait_sig(1, 1'b0, 12, n);
    check("timeout width", n >= 4 && n <= 8, 1'b1);
    wait_sig(0, 1'b1, 60, n);
    check("merged release", n < 60, 1'b1);
    kick_on = 1'b1;
    step(14);
    check("kick after timeout", wd_expired, 1'b0);
    // Re-enable with a 100 ms start wait and no kicks at all
    kick_on = 1'b0;
    cfg.wd_enable = 1'b0;
    step(1);
    cfg.start_sel = 4'h1;
    cfg.to_gpo = 1'b0;
    cfg.to_reset = 1'b0;
    cfg.wd_enable = 1'b1;
    reconf();
    wait_sig(1, 1'b1, 360, n);
    check("start wait quiet", n == 360, 1'b1);
    wait_sig(1, 1'b1, 120, n);
    check("after start wait", n < 120, 1'b1);
    check("gpo route off", timeout_gpo, 1'b0);
    check("reset not merged", sys_reset_n, 1'b1);
    cfg.wd_enable = 1'b0;
    cfg.pulse_mode = 1'b1;
    reconf();
    wait_sig(0, 1'b1, 40, n);
    check("pulse 3 ms", n >= 8 && n <= 22, 1'b1);
    // A rail below its off threshold is no longer above its on threshold
    rail_pg_on = 24'h0;
    rail_below_pg_off = 24'h1;
    step(3);
    check("single pulse", sys_reset_n, 1'b1);
    rail_pg_on = 24'h1;
    rail_below_pg_off = 24'h0;
    step(2);
    check("rearmed pulse", sys_reset_n, 1'b0);
    give_verdict();
  end

  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
endmodule // watchdog_and_system_reset_bench
